//--- hw/csd_dma_map.vh
// Register map, field positions and reset values of the DMA channel
`ifndef CSD_DMA_MAP_VH
`define CSD_DMA_MAP_VH

// Register indices; the byte address on the bus is four times the index
`define CSD_A_BASE_IDX      16'h1250
`define CSD_A_INDEX_IDX     16'h1254
`define CSD_B_BASE_IDX      16'h1256
`define CSD_B_INDEX_IDX     16'h125A
`define CSD_LEN_IDX         16'h125E
`define CSD_CTRL_IDX        16'h1260

// Control register field positions
`define CSD_CTRL_ON         0
`define CSD_CTRL_DIR        2
`define CSD_CTRL_FIXED      3
`define CSD_CTRL_TRIG_MODE  5
`define CSD_CTRL_B_STEP_LO  6
`define CSD_CTRL_B_STEP_HI  7
`define CSD_CTRL_A_STEP_LO  8
`define CSD_CTRL_A_STEP_HI  9
`define CSD_CTRL_CIRC       10
`define CSD_CTRL_ABORT      11
`define CSD_CTRL_SYNC_SEL   14

// Step field encodings
`define CSD_STEP_NONE       2'b00
`define CSD_STEP_WORD       2'b10

// Index advance for one word, in bytes
`define CSD_WORD_BYTES      8'h02

// Reset values
`define CSD_LEN_RST         8'h00
`define CSD_IDX_RST         8'h00
`define CSD_BASE_RST        13'h0000
`define CSD_STEP_RST        2'b00
`define CSD_BIT_RST         1'b0

`endif

//--- hw/csd_sync.v
// Two-flop synchroniser for signals arriving from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module csd_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_r;

  // The first stage feeds only the second one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{1'b0}};
      q      <= {WIDTH{1'b0}};
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire

//--- hw/csd_dma_channel.v
// Single-channel word DMA engine with APB registers and codec pacing
`timescale 1ns/100ps
`default_nettype none
`include "csd_dma_map.vh"
module csd_dma_channel #(
  parameter ADDR_W = 13,
  parameter IDX_W  = 8,
  parameter DATA_W = 16
) (
  input  wire              REF_CLK,
  input  wire              RESET_N,
  input  wire              CLK_EN,
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [15:0]       PADDR,
  input  wire [31:0]       PWDATA,
  output reg  [31:0]       PRDATA,
  output reg               PREADY,
  output reg               PSLVERR,
  input  wire              CODEC_TRIG,
  output reg               MEM_REQ,
  output reg               MEM_WRITE,
  output reg  [ADDR_W-1:0] MEM_ADDR,
  output reg  [DATA_W-1:0] MEM_WDATA,
  input  wire [DATA_W-1:0] MEM_RDATA,
  input  wire              MEM_ACK,
  output reg               CHAN_ACTIVE
);

  localparam [4:0] S_IDLE = 5'b0_0001;
  localparam [4:0] S_WAIT = 5'b0_0010;
  localparam [4:0] S_RD   = 5'b0_0100;
  localparam [4:0] S_WR   = 5'b0_1000;
  localparam [4:0] S_STEP = 5'b1_0000;

  localparam [5:0] SEL_A_BASE  = 6'b00_0001;
  localparam [5:0] SEL_A_INDEX = 6'b00_0010;
  localparam [5:0] SEL_B_BASE  = 6'b00_0100;
  localparam [5:0] SEL_B_INDEX = 6'b00_1000;
  localparam [5:0] SEL_LEN     = 6'b01_0000;
  localparam [5:0] SEL_CTRL    = 6'b10_0000;

  // Byte address of a register from its index
  function [15:0] reg_addr;
    input [15:0] idx;
    begin
      reg_addr = {idx[13:0], 2'b00};
    end
  endfunction

  // One-hot register select, shared by the read and write paths
  function [5:0] reg_dec;
    input [15:0] addr;
    begin
      reg_dec = 6'b00_0000;
      if (addr == reg_addr(`CSD_A_BASE_IDX))
        reg_dec = SEL_A_BASE;
      if (addr == reg_addr(`CSD_A_INDEX_IDX))
        reg_dec = SEL_A_INDEX;
      if (addr == reg_addr(`CSD_B_BASE_IDX))
        reg_dec = SEL_B_BASE;
      if (addr == reg_addr(`CSD_B_INDEX_IDX))
        reg_dec = SEL_B_INDEX;
      if (addr == reg_addr(`CSD_LEN_IDX))
        reg_dec = SEL_LEN;
      if (addr == reg_addr(`CSD_CTRL_IDX))
        reg_dec = SEL_CTRL;
    end
  endfunction

  // Index advance; the reserved codes advance nothing
  function [IDX_W-1:0] step_of;
    input [1:0] code;
    begin
      if (code == `CSD_STEP_WORD)
        step_of = `CSD_WORD_BYTES;
      else
        step_of = {IDX_W{1'b0}};
    end
  endfunction

  reg              rst_meta_r;
  reg              rst_sync_r;
  wire             rst_n;
  wire             trig_sync;
  reg              trig_prev_r;
  reg              trig_pend_r;
  reg  [4:0]       state_r;
  reg  [IDX_W-1:0] len_r;
  reg  [ADDR_W-1:0] a_base_r;
  reg  [ADDR_W-1:0] b_base_r;
  reg  [IDX_W-1:0] a_idx_r;
  reg  [IDX_W-1:0] b_idx_r;
  reg              on_r;
  reg              dir_r;
  reg              fixed_one_r;
  reg              trig_mode_r;
  reg  [1:0]       b_step_r;
  reg  [1:0]       a_step_r;
  reg              circ_r;
  reg              abort_en_r;
  reg              sync_sel_r;
  wire [5:0]       sel;
  wire             apb_setup;
  wire             apb_wr;
  wire [ADDR_W-1:0] a_addr;
  wire [ADDR_W-1:0] b_addr;
  wire [ADDR_W-1:0] src_addr;
  wire [ADDR_W-1:0] dst_addr;
  wire             at_end;
  wire             kill;
  wire             trig_edge;
  wire             ctrl_wr;
  reg  [15:0]      rd_word;

  // Reset is released through two flops so every flop reset by rst_n leaves reset together
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else if (CLK_EN) begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  csd_sync #(
    .WIDTH (1)
  ) u_trig_sync (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .ce    (CLK_EN),
    .d     (CODEC_TRIG),
    .q     (trig_sync)
  );

  assign sel       = reg_dec(PADDR);
  assign apb_setup = PSEL & ~PENABLE & ~PREADY;
  assign apb_wr    = PSEL & PENABLE & PREADY & PWRITE;
  assign ctrl_wr   = apb_wr & sel[5];

  assign a_addr   = a_base_r + {{(ADDR_W-IDX_W){1'b0}}, a_idx_r};
  assign b_addr   = b_base_r + {{(ADDR_W-IDX_W){1'b0}}, b_idx_r};
  assign src_addr = dir_r ? b_addr : a_addr;
  assign dst_addr = dir_r ? a_addr : b_addr;
  assign at_end   = (a_idx_r == len_r);
  assign kill     = ~on_r & abort_en_r;
  assign trig_edge = trig_sync & ~trig_prev_r;

  always @* begin
    rd_word = 16'h0000;
    case (sel)
      SEL_A_BASE:  rd_word = {{(16-ADDR_W){1'b0}}, a_base_r};
      SEL_A_INDEX: rd_word = {{(16-IDX_W){1'b0}}, a_idx_r};
      SEL_B_BASE:  rd_word = {{(16-ADDR_W){1'b0}}, b_base_r};
      SEL_B_INDEX: rd_word = {{(16-IDX_W){1'b0}}, b_idx_r};
      SEL_LEN:     rd_word = {{(16-IDX_W){1'b0}}, len_r};
      SEL_CTRL: begin
        rd_word[`CSD_CTRL_ON]        = on_r;
        rd_word[`CSD_CTRL_DIR]       = dir_r;
        rd_word[`CSD_CTRL_FIXED]     = fixed_one_r;
        rd_word[`CSD_CTRL_TRIG_MODE] = trig_mode_r;
        rd_word[`CSD_CTRL_B_STEP_HI:`CSD_CTRL_B_STEP_LO] = b_step_r;
        rd_word[`CSD_CTRL_A_STEP_HI:`CSD_CTRL_A_STEP_LO] = a_step_r;
        rd_word[`CSD_CTRL_CIRC]      = circ_r;
        rd_word[`CSD_CTRL_ABORT]     = abort_en_r;
        rd_word[`CSD_CTRL_SYNC_SEL]  = sync_sel_r;
      end
      default:     rd_word = 16'h0000;
    endcase
  end

  // APB slave: answers in the first access cycle
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else if (CLK_EN) begin
      PREADY <= apb_setup;
      if (apb_setup) begin
        PRDATA  <= PWRITE ? 32'h0000_0000 : {16'h0000, rd_word};
        PSLVERR <= (sel == 6'b00_0000);
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // Plain configuration registers
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      len_r       <= `CSD_LEN_RST;
      a_base_r    <= `CSD_BASE_RST;
      b_base_r    <= `CSD_BASE_RST;
      dir_r       <= `CSD_BIT_RST;
      fixed_one_r <= `CSD_BIT_RST;
      trig_mode_r <= `CSD_BIT_RST;
      b_step_r    <= `CSD_STEP_RST;
      a_step_r    <= `CSD_STEP_RST;
      circ_r      <= `CSD_BIT_RST;
      abort_en_r  <= `CSD_BIT_RST;
      sync_sel_r  <= `CSD_BIT_RST;
    end else if (CLK_EN) begin
      if (apb_wr & sel[4])
        len_r <= PWDATA[IDX_W-1:0];
      if (apb_wr & sel[0])
        a_base_r <= PWDATA[ADDR_W-1:0];
      if (apb_wr & sel[2])
        b_base_r <= PWDATA[ADDR_W-1:0];
      if (ctrl_wr) begin
        dir_r       <= PWDATA[`CSD_CTRL_DIR];
        fixed_one_r <= PWDATA[`CSD_CTRL_FIXED];
        trig_mode_r <= PWDATA[`CSD_CTRL_TRIG_MODE];
        b_step_r    <= PWDATA[`CSD_CTRL_B_STEP_HI:`CSD_CTRL_B_STEP_LO];
        a_step_r    <= PWDATA[`CSD_CTRL_A_STEP_HI:`CSD_CTRL_A_STEP_LO];
        circ_r      <= PWDATA[`CSD_CTRL_CIRC];
        abort_en_r  <= PWDATA[`CSD_CTRL_ABORT];
        sync_sel_r  <= PWDATA[`CSD_CTRL_SYNC_SEL];
      end
    end
  end

  // Trigger capture; a pulse arriving as one is consumed is kept
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_r <= 1'b0;
      trig_pend_r <= 1'b0;
    end else if (CLK_EN) begin
      trig_prev_r <= trig_sync;
      if (trig_edge & on_r & trig_mode_r)
        trig_pend_r <= 1'b1;
      else if (~on_r | (state_r == S_WAIT & trig_pend_r))
        trig_pend_r <= 1'b0;
    end
  end

  // Transfer engine; a word is only started while the channel is on, and one in flight runs on after it is turned off unless abort is enabled
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= S_IDLE;
      on_r        <= `CSD_BIT_RST;
      a_idx_r     <= `CSD_IDX_RST;
      b_idx_r     <= `CSD_IDX_RST;
      MEM_REQ     <= 1'b0;
      MEM_WRITE   <= 1'b0;
      MEM_ADDR    <= {ADDR_W{1'b0}};
      MEM_WDATA   <= {DATA_W{1'b0}};
      CHAN_ACTIVE <= 1'b0;
    end else if (CLK_EN) begin
      if (apb_wr & sel[1])
        a_idx_r <= PWDATA[IDX_W-1:0];
      if (apb_wr & sel[3])
        b_idx_r <= PWDATA[IDX_W-1:0];
      CHAN_ACTIVE <= on_r | (state_r != S_IDLE);
      case (state_r)
        S_IDLE: begin
          if (on_r) begin
            if (at_end) begin
              if (circ_r) begin
                a_idx_r <= `CSD_IDX_RST;
                b_idx_r <= `CSD_IDX_RST;
              end else begin
                on_r <= 1'b0;
              end
            end else if (trig_mode_r) begin
              state_r <= S_WAIT;
            end else begin
              state_r   <= S_RD;
              MEM_REQ   <= 1'b1;
              MEM_WRITE <= 1'b0;
              MEM_ADDR  <= src_addr;
            end
          end
        end
        S_WAIT: begin
          if (~on_r) begin
            state_r <= S_IDLE;
          end else if (trig_pend_r) begin
            state_r   <= S_RD;
            MEM_REQ   <= 1'b1;
            MEM_WRITE <= 1'b0;
            MEM_ADDR  <= src_addr;
          end
        end
        S_RD: begin
          if (kill) begin
            state_r <= S_IDLE;
            MEM_REQ <= 1'b0;
          end else if (MEM_ACK) begin
            state_r   <= S_WR;
            MEM_WRITE <= 1'b1;
            MEM_ADDR  <= dst_addr;
            MEM_WDATA <= MEM_RDATA;
          end
        end
        S_WR: begin
          if (kill) begin
            state_r   <= S_IDLE;
            MEM_REQ   <= 1'b0;
            MEM_WRITE <= 1'b0;
          end else if (MEM_ACK) begin
            state_r   <= S_STEP;
            MEM_REQ   <= 1'b0;
            MEM_WRITE <= 1'b0;
          end
        end
        S_STEP: begin
          // Engine step outranks a software index write in the same cycle
          a_idx_r <= a_idx_r + step_of(a_step_r);
          b_idx_r <= b_idx_r + step_of(b_step_r);
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
          MEM_REQ <= 1'b0;
        end
      endcase
      // A software write of the on bit outranks the automatic clear
      if (ctrl_wr)
        on_r <= PWDATA[`CSD_CTRL_ON];
    end
  end

endmodule
`default_nettype wire

//--- verification/csd_dma_chk.sv
// Port timing checker for the DMA channel
`timescale 1ns/100ps
`default_nettype none
module csd_dma_chk #(
  parameter ADDR_W = 13,
  parameter DATA_W = 16
) (
  input wire logic              REF_CLK,
  input wire logic              RESET_N,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              MEM_REQ,
  input wire logic              MEM_WRITE,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic [DATA_W-1:0] MEM_WDATA,
  input wire logic [DATA_W-1:0] MEM_RDATA,
  input wire logic              MEM_ACK,
  input wire logic              CHAN_ACTIVE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  a_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_once: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_upper_zero: assert property (PREADY |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_req_hold: assert property (MEM_REQ && !MEM_ACK |=>
    !MEM_REQ || $stable(MEM_ADDR) && $stable(MEM_WRITE))
    else $error("request changed before ack");
  a_read_write: assert property (
    MEM_REQ && MEM_ACK && !MEM_WRITE |=> MEM_REQ && MEM_WRITE)
    else $error("no write after read");
  a_wdata_copy: assert property (
    MEM_REQ && MEM_ACK && !MEM_WRITE |=> MEM_WDATA == $past(MEM_RDATA))
    else $error("write data not the word read");
  a_word_read: assert property ($rose(MEM_REQ) |-> !MEM_WRITE)
    else $error("word began with a write");
  c_err: cover property (PREADY && PSLVERR);
  c_wr: cover property (MEM_ACK && MEM_WRITE);
  c_stop: cover property ($fell(CHAN_ACTIVE));
endmodule
bind csd_dma_channel csd_dma_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ),
  .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
  .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .CHAN_ACTIVE(CHAN_ACTIVE));
`default_nettype wire

//--- verification/csd_mem_model.sv
// Word memory answering the channel's memory port
`timescale 1ns/100ps
`default_nettype none
module csd_mem_model (
  input  wire logic        clk,
  input  wire logic [7:0]  dly,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [12:0] addr,
  input  wire logic [15:0] wdata,
  output var  logic        ack,
  output var  logic [15:0] rdata
);
  logic [15:0] mem [0:4095];
  logic [7:0]  cnt;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 16'h1000 + 16'(i);
    ack = 1'b0;
    rdata = 16'h0000;
    cnt = 8'h00;
  end
  // Data toggles outside the ack cycle so a stale word is never mistaken
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (!req || ack) cnt <= 8'h00;
    else if (cnt >= dly) begin
      ack <= 1'b1;
      rdata <= mem[addr[12:1]];
      if (wr) mem[addr[12:1]] <= wdata;
    end else cnt <= cnt + 8'h01;
  end
endmodule
`default_nettype wire

//--- verification/csd_dma_channel_tb_top.sv
// Register level test of the DMA channel
`timescale 1ns/100ps
`default_nettype none
module csd_dma_channel_tb_top;
  localparam logic [15:0] AB = 16'h4940, AI = 16'h4950, BB = 16'h4958;
  localparam logic [15:0] BI = 16'h4968, LEN = 16'h4978, CTRL = 16'h4980;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, trig = 0;
  logic        pready, pslverr, mreq, mwr, mack, act, er;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [12:0] maddr;
  logic [15:0] mwd, mrd;
  logic [7:0]  dly = 8'h00;
  logic        ce = 1'b1;
  int          bad_count = 0, check_count = 0;
  csd_dma_channel DUT (.REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(ce),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CODEC_TRIG(trig), .MEM_REQ(mreq), .MEM_WRITE(mwr), .MEM_ADDR(maddr),
    .MEM_WDATA(mwd), .MEM_RDATA(mrd), .MEM_ACK(mack), .CHAN_ACTIVE(act));
  csd_mem_model u_mem (.clk(clk), .dly(dly), .req(mreq), .wr(mwr),
    .addr(maddr), .wdata(mwd), .ack(mack), .rdata(mrd));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  // Polls until the engine drops its own on bit
  task automatic wait_off;
    for (int i = 0; i < 100; i++) begin
      xfer(1'b0, CTRL, 32'h0000_0000);
      if (rd[0] === 1'b0) break;
    end
  endtask
  task automatic pulse;
    trig <= 1'b1;
    repeat (4) @(posedge clk);
    trig <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(LEN, 32'h0000_0000);
    rdchk(CTRL, 32'h0000_0000);
    xfer(1'b0, 16'h4000, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    xfer(1'b1, LEN, 32'hFFFF_ABFE);
    rdchk(LEN, 32'h0000_00FE);
    xfer(1'b1, AB, 32'h0000_0100);
    xfer(1'b1, BB, 32'h0000_0400);
    xfer(1'b1, LEN, 32'h0000_0006);
    xfer(1'b1, CTRL, 32'h0000_0289);
    wait_off();
    rdchk(CTRL, 32'h0000_0288);
    rdchk(AI, 32'h0000_0006);
    rdchk(BI, 32'h0000_0006);
    for (int k = 0; k < 3; k++)
      chk({16'h0, u_mem.mem[512 + k]}, 32'h1080 + k);
    xfer(1'b1, AI, 32'h0000_0000);
    xfer(1'b1, BI, 32'h0000_0000);
    xfer(1'b1, LEN, 32'h0000_0004);
    xfer(1'b1, CTRL, 32'h0000_020D);
    wait_off();
    rdchk(AI, 32'h0000_0004);
    rdchk(BI, 32'h0000_0000);
    chk({16'h0, u_mem.mem[129]}, 32'h0000_1080);
    xfer(1'b1, AI, 32'h0000_0000);
    xfer(1'b1, CTRL, 32'h0000_06A9);
    repeat (30) @(posedge clk);
    rdchk(AI, 32'h0000_0000);
    chk({31'h0, act}, 32'h0000_0001);
    repeat (3) pulse();
    rdchk(AI, 32'h0000_0002);
    rdchk(BI, 32'h0000_0002);
    rdchk(CTRL, 32'h0000_06A9);
    // Frozen clock enable must let a trigger pulse pass unseen
    ce <= 1'b0;
    pulse();
    ce <= 1'b1;
    rdchk(AI, 32'h0000_0002);
    dly <= 8'h28;
    pulse();
    xfer(1'b1, CTRL, 32'h0000_0EA9);
    xfer(1'b1, CTRL, 32'h0000_0EA8);
    repeat (2) @(posedge clk);
    chk({31'h0, mreq}, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk({31'h0, act}, 32'h0000_0000);
    rdchk(AI, 32'h0000_0002);
    report_and_stop();
  end
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
